// >>> hw/manchester_codec_defines.svh
// timing constants and loopback codes for the manchester codec unit
// assumes a 250 MHz system clock and a 10 Mb/s line
`ifndef MANCHESTER_CODEC_DEFINES_SVH
`define MANCHESTER_CODEC_DEFINES_SVH

// system clock period in ns
`define MC_CLK_NS 4
// line rate in Mb/s and the bit time it implies
`define MC_LINE_MBPS 10
`define MC_BIT_NS (1000 / `MC_LINE_MBPS)
// half-bit time, one period of the 20 MHz oscillator
`define MC_HALF_NS (`MC_BIT_NS / 2)
// edges closer than three quarters of a bit to the last mid-bit edge
// are bit-boundary edges; least time, so round up
`define MC_GUARD_NS ((`MC_BIT_NS * 3) / 4)
`define MC_GUARD_CYC ((`MC_GUARD_NS + `MC_CLK_NS - 1) / `MC_CLK_NS)
// recovered clock stays high for half a bit; longest time, round down
`define MC_RXCLK_HI_CYC (`MC_HALF_NS / `MC_CLK_NS)
// activity ends after one and a half bits without any edge
`define MC_IDLE_NS ((`MC_BIT_NS * 3) / 2)
`define MC_IDLE_CYC (`MC_IDLE_NS / `MC_CLK_NS)
// loopback selector codes
`define MC_LOOP_NONE 2'h0
`define MC_LOOP_MAC 2'h1
`define MC_LOOP_CODEC 2'h2
`define MC_LOOP_XCVR 2'h3

`endif

// >>> hw/manchester_codec_pkg.sv
// types shared by the manchester codec unit and its decoder
// assumes manchester_codec_defines.svh is on the include path
package manchester_codec_pkg;

    // loopback selection, codes written out here, equal to those in the defines header
    typedef enum logic [1:0] {
        LOOP_NONE = 2'h0,
        LOOP_MAC = 2'h1,
        LOOP_CODEC = 2'h2,
        LOOP_XCVR = 2'h3
    } loop_mode_e;

    // receive state of the decoder, one-hot
    typedef enum logic [2:0] {
        DEC_IDLE = 3'b001,
        DEC_ACTIVE = 3'b010,
        DEC_DRAIN = 3'b100
    } dec_state_e;

    // everything the codec hands to the media access controller
    typedef struct packed {
        logic rx_data;
        logic rx_clock;
        logic carrier_present;
        logic collision;
        logic tx_bit_clock;
    } mac_side_s;

    // serial transmit signals from the media access controller
    typedef struct packed {
        logic tx_en;
        logic tx_data;
    } mac_tx_s;

endpackage : manchester_codec_pkg

// >>> hw/manchester_codec_unit.sv
// manchester codec between a coax transceiver and a mac
// assumes all pin inputs synchronous to clk_sys; osc_20m is sampled
// as a level, so clk_sys must run well above 40 MHz
// edges on the receive pair are timed on clk_sys, no analog loop
// every output is registered; pins mirror what the mac sees
// Contract
// - transmit merges mac nrz bits and bit clock into manchester symbols.
// - receive recovers nrz data and a receive clock at 10 Mb/s.
// - carrier_present follows data activity on the receive pair.
// - collision is flagged while a 10 MHz signal is on the collision pair.
// - tx_bit_clock is the 20 MHz oscillator divided by two.
// - every signal sent to the mac is also a device output pin.
// - three loopbacks are selectable: at mac, at codec, at transceiver.
// - while sending, the returned own frame is received for monitoring.
// - external_codec_select high bypasses the codec, mac signals go to pins.
`timescale 1ns/1ps
`include "manchester_codec_defines.svh"

module manchester_codec_unit
    import manchester_codec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic osc_20m,
    input wire logic external_codec_select,
    input wire loop_mode_e loop_mode,
    input wire mac_tx_s mac_tx,
    output mac_side_s mac_side,
    output mac_side_s pin_side,
    input wire logic rx_line,
    input wire logic col_line,
    output logic tx_line_p,
    output logic tx_line_n,
    output logic own_frame_seen,
    output mac_tx_s ext_tx,
    input wire mac_side_s ext_in
);

    logic osc_q;
    logic osc_rise;
    logic half_q;
    logic bit_q;
    logic en_q;
    logic enc_line_q;
    logic dec_in;
    logic rx_active;
    logic rx_bit;
    logic rx_clk;
    logic col_active;
    logic line_out;
    mac_side_s side_d;

    // codec loopback turns the encoder straight into the decoder
    function automatic logic codec_loop_on(input loop_mode_e mode);
        codec_loop_on = (mode == LOOP_CODEC);
    endfunction : codec_loop_on

    // mac loopback applies only while the internal codec is in use
    function automatic logic mac_loop_on(input loop_mode_e mode,
        input logic bypass);
        mac_loop_on = !bypass && (mode == LOOP_MAC);
    endfunction : mac_loop_on

    // the pair stays silent in mac or codec loopback and in bypass, so
    // a bypass raised mid-frame cuts the line without waiting for the
    // next bit boundary
    function automatic logic line_muted(input loop_mode_e mode,
        input logic bypass);
        line_muted = bypass || mac_loop_on(mode, bypass) ||
            codec_loop_on(mode);
    endfunction : line_muted

    // oscillator rising edge marks each half-bit
    assign osc_rise = osc_20m & ~osc_q;

    // previous oscillator level; resets high so that an oscillator
    // already high at release is not taken for a rise, which would
    // shorten the first bit clock period
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            osc_q <= 1'b1;
        end else begin
            osc_q <= osc_20m;
        end
    end

    // divide by two
    // half_q is the bit clock itself: low for the first half of a bit
    // and high for the second, so its fall is the bit boundary
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            half_q <= 1'b0;
        end else if (osc_rise) begin
            half_q <= ~half_q;
        end
    end

    // latch mac bit
    // the mac launches a bit at the rise of the bit clock; taking it at
    // the following fall leaves half a bit of setup on each side
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bit_q <= 1'b0;
            en_q <= 1'b0;
        end else if (osc_rise && half_q) begin
            bit_q <= mac_tx.tx_data;
            en_q <= mac_tx.tx_en && !external_codec_select;
        end
    end

    // first half inverted
    // a one is low then high and a zero high then low, so the mid-bit
    // edge carries the data and a boundary edge only appears between
    // equal bits
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enc_line_q <= 1'b0;
        end else begin
            enc_line_q <= en_q && (half_q ? bit_q : ~bit_q);
        end
    end

    // codec loopback input
    // the receive pair is ignored here, so line noise cannot reach the
    // mac while the codec checks itself
    assign dec_in = codec_loop_on(loop_mode) ? enc_line_q : rx_line;

    manchester_decoder u_rx_dec (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .line_in(dec_in),
        .active(rx_active),
        .bit_data(rx_bit),
        .bit_strobe(),
        .bit_clock(rx_clk)
    );

    // collision activity
    // a second decoder used only for its activity flag; any burst of
    // edges counts, the frequency itself is not measured
    manchester_decoder u_col_det (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .line_in(col_line),
        .active(col_active),
        .bit_data(),
        .bit_strobe(),
        .bit_clock()
    );

    // line is quiet during mac and codec loopback and in bypass
    assign line_out = en_q && !line_muted(loop_mode, external_codec_select);

    // differential transmit pair, both low when idle
    // so no standing level is left on the pair between frames
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_line_p <= 1'b0;
            tx_line_n <= 1'b0;
        end else begin
            tx_line_p <= line_out && enc_line_q;
            tx_line_n <= line_out && !enc_line_q;
        end
    end

    // select what the mac sees
    // bypass wins over every loopback: the internal codec is then unused
    always_comb begin
        side_d.tx_bit_clock = half_q;
        side_d.rx_data = rx_bit;
        side_d.rx_clock = rx_clk;
        side_d.carrier_present = rx_active;
        side_d.collision = col_active;
        if (external_codec_select) begin
            side_d = ext_in;
        end else if (mac_loop_on(loop_mode, external_codec_select)) begin
            side_d.rx_data = mac_tx.tx_data;
            side_d.rx_clock = half_q;
            side_d.carrier_present = mac_tx.tx_en;
            side_d.collision = 1'b0;
        end
    end

    // same values on both sides
    // two registers from one source keep pins and mac in the same cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mac_side <= '0;
            pin_side <= '0;
        end else begin
            mac_side <= side_d;
            pin_side <= side_d;
        end
    end

    // mac transmit out to pins
    // outside bypass the pins rest at zero, so an unused external codec
    // never sees a frame
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_tx <= '0;
        end else if (external_codec_select) begin
            ext_tx <= mac_tx;
        end else begin
            ext_tx <= '0;
        end
    end

    // own frame received while sending
    // carrier while our own encoder runs can only be the returned frame
    // as long as no collision is in progress
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            own_frame_seen <= 1'b0;
        end else begin
            own_frame_seen <= en_q && side_d.carrier_present;
        end
    end

endmodule : manchester_codec_unit

// >>> hw/manchester_decoder.sv
// edge-timing manchester decoder and activity detector
// assumes line_in is already synchronous to clk_sys
`timescale 1ns/1ps
`include "manchester_codec_defines.svh"

module manchester_decoder
    import manchester_codec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic line_in,
    output logic active,
    output logic bit_data,
    output logic bit_strobe,
    output logic bit_clock
);

    logic prev_q;
    logic [7:0] since_q;
    logic [7:0] idle_q;
    dec_state_e state_q;
    logic any_edge;
    logic mid_edge;

    // a mid-bit edge is the first edge of a burst or any edge past the guard
    assign any_edge = line_in ^ prev_q;
    assign mid_edge = any_edge &&
        (state_q != DEC_ACTIVE || since_q >= 8'(`MC_GUARD_CYC));

    // previous line level for edge detection
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= line_in;
        end
    end

    // time since last mid-bit edge, saturating
    always_ff @(posedge clk_sys) begin
        if (sys_rst || mid_edge) begin
            since_q <= 8'h00;
        end else if (since_q != 8'hff) begin
            since_q <= since_q + 8'h01;
        end
    end

    // time since any edge, saturating
    always_ff @(posedge clk_sys) begin
        if (sys_rst || any_edge) begin
            idle_q <= 8'h00;
        end else if (idle_q != 8'hff) begin
            idle_q <= idle_q + 8'h01;
        end
    end

    // activity tracking: edges start it, a quiet line ends it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= DEC_IDLE;
        end else begin
            case (state_q)
                DEC_IDLE: begin
                    if (any_edge) begin
                        state_q <= DEC_ACTIVE;
                    end
                end
                DEC_ACTIVE: begin
                    if (idle_q >= 8'(`MC_IDLE_CYC)) begin
                        state_q <= DEC_DRAIN;
                    end
                end
                DEC_DRAIN: begin
                    state_q <= DEC_IDLE;
                end
                default: begin
                    state_q <= DEC_IDLE;
                end
            endcase
        end
    end

    // nrz bit equals the level after the mid-bit edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bit_data <= 1'b0;
            bit_strobe <= 1'b0;
            bit_clock <= 1'b0;
            active <= 1'b0;
        end else begin
            active <= (state_q == DEC_ACTIVE);
            bit_strobe <= mid_edge;
            if (mid_edge) begin
                bit_data <= line_in;
            end
            bit_clock <= mid_edge || (state_q == DEC_ACTIVE &&
                since_q < 8'(`MC_RXCLK_HI_CYC - 1));
        end
    end

endmodule : manchester_decoder

// >>> sim/coax_xcvr_model.sv
// coax transceiver model: echoes the transmit pair, sends frames
// assumes pins synchronous to the 250 MHz clock
`timescale 1ns/1ps
module coax_xcvr_model (
    input wire logic clk_sys,
    input wire logic tx_line_p,
    input wire logic col_req,
    output logic rx_line,
    output logic col_line
);
    logic drv_q = 1'b0;
    logic [4:0] cnt_q = 5'h00;
    initial rx_line = 1'b0;
    initial col_line = 1'b0;
    // own transmission always returns; idle pair rests low
    always @(posedge clk_sys) rx_line <= tx_line_p | drv_q;
    // 10 MHz burst on the collision pair while asked
    always @(posedge clk_sys) begin
        cnt_q <= (cnt_q == 5'h18) ? 5'h00 : cnt_q + 5'h01;
        if (!col_req) col_line <= 1'b0;
        else if (cnt_q == 5'h00 || cnt_q == 5'h0c) col_line <= ~col_line;
    end
    // far frame, one means low half then high half
    task automatic send_bits(input logic [15:0] b);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_sys);
            drv_q <= ~b[i];
            repeat (12) @(posedge clk_sys);
            drv_q <= b[i];
            repeat (12) @(posedge clk_sys);
        end
        drv_q <= 1'b0;
        repeat (80) @(posedge clk_sys);
    endtask : send_bits
endmodule : coax_xcvr_model

// >>> sim/codec_monitor.sv
// checker for the manchester codec unit ports
// assumes a bind onto manchester_codec_unit, one clock domain
`timescale 1ns/1ps
module codec_monitor
    import manchester_codec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic external_codec_select,
    input wire loop_mode_e loop_mode,
    input wire mac_tx_s mac_tx,
    input wire mac_side_s mac_side,
    input wire mac_side_s pin_side,
    input wire logic rx_line,
    input wire logic col_line,
    input wire logic tx_line_p,
    input wire logic tx_line_n,
    input wire mac_tx_s ext_tx,
    input wire mac_side_s ext_in
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // an edge on the receive pair on the normal path
    sequence rx_edge_s;
        $changed(rx_line) && !external_codec_select &&
            (loop_mode == LOOP_NONE || loop_mode == LOOP_XCVR);
    endsequence
    // loopback or bypass held that keeps the line silent
    sequence quiet_s;
        (loop_mode == LOOP_MAC || loop_mode == LOOP_CODEC ||
            external_codec_select) [*3];
    endsequence
    pin_mirror_a: assert property (pin_side == mac_side)
        else $error("pin side differs from mac side");
    tx_diff_a: assert property ((tx_line_p | tx_line_n) |->
        tx_line_p != tx_line_n) else $error("tx pair not differential");
    line_quiet_a: assert property (quiet_s |->
        !tx_line_p && !tx_line_n) else $error("line not silent");
    carrier_seen_a: assert property (rx_edge_s |->
        ##[1:4] mac_side.carrier_present) else $error("no carrier");
    collision_seen_a: assert property ($changed(col_line) &&
        !external_codec_select && loop_mode == LOOP_NONE |->
        ##[1:4] mac_side.collision) else $error("no collision");
    mac_loop_a: assert property ($past(loop_mode == LOOP_MAC &&
        !external_codec_select) |-> !mac_side.collision &&
        mac_side.carrier_present == $past(mac_tx.tx_en))
        else $error("mac loopback carrier wrong");
    bypass_out_a: assert property (external_codec_select[*2] |->
        ext_tx == $past(mac_tx) && mac_side == $past(ext_in))
        else $error("bypass routing wrong");
    bit_clock_a: assert property (disable iff (sys_rst ||
        external_codec_select) $rose(mac_side.tx_bit_clock) |->
        ##[24:26] $rose(mac_side.tx_bit_clock))
        else $error("tx bit clock period wrong");
endmodule : codec_monitor

bind manchester_codec_unit codec_monitor u_mon (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .external_codec_select(external_codec_select),
    .loop_mode(loop_mode), .mac_tx(mac_tx), .mac_side(mac_side),
    .pin_side(pin_side), .rx_line(rx_line), .col_line(col_line),
    .tx_line_p(tx_line_p), .tx_line_n(tx_line_n), .ext_tx(ext_tx),
    .ext_in(ext_in));

// >>> sim/manchester_codec_unit_tb.sv
// bench for the codec unit: echo, receive, collision, loops, bypass
// assumes the transceiver model and the bound monitor
`timescale 1ns/1ps
module manchester_codec_unit_tb
    import manchester_codec_pkg::*;
;
    logic clk_sys = 1'b0, sys_rst = 1'b1, osc_20m = 1'b0;
    logic external_codec_select = 1'b0, col_req = 1'b0;
    loop_mode_e loop_mode = LOOP_NONE;
    loop_mode_e modes [3] = '{LOOP_MAC, LOOP_CODEC, LOOP_XCVR};
    mac_tx_s mac_tx = 2'h0, ext_tx;
    mac_side_s mac_side, pin_side, ext_in = 5'h00;
    logic rx_line, col_line, tx_line_p, tx_line_n, own_frame_seen;
    logic [7:0] sh_q = 8'h00;
    logic rxc_q = 1'b0, car_q = 1'b0, tx_q = 1'b0, own_q = 1'b0;
    int err_total = 0, comparisons = 0, cyc = 0;
    longint t0;
    initial forever #2 clk_sys = ~clk_sys;
    initial forever #25 osc_20m <= ~osc_20m;
    manchester_codec_unit u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .osc_20m(osc_20m), .external_codec_select(external_codec_select),
        .loop_mode(loop_mode), .mac_tx(mac_tx), .mac_side(mac_side),
        .pin_side(pin_side), .rx_line(rx_line), .col_line(col_line),
        .tx_line_p(tx_line_p), .tx_line_n(tx_line_n),
        .own_frame_seen(own_frame_seen), .ext_tx(ext_tx), .ext_in(ext_in));
    coax_xcvr_model u_xcvr (.clk_sys(clk_sys), .tx_line_p(tx_line_p),
        .col_req(col_req), .rx_line(rx_line), .col_line(col_line));
    // shift data at receive clock rises, keep sticky flags, watchdog
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        rxc_q <= mac_side.rx_clock;
        if (mac_side.rx_clock && !rxc_q) sh_q <= {sh_q[6:0], mac_side.rx_data};
        car_q <= car_q | mac_side.carrier_present;
        tx_q <= tx_q | tx_line_p;
        own_q <= own_q | own_frame_seen;
        if (cyc == 30000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic clr;
        @(negedge clk_sys);
        car_q = 1'b0;
        tx_q = 1'b0;
        own_q = 1'b0;
    endtask : clr
    // mac serial bits, each launched after a bit clock rise
    task automatic mac_send(input logic [15:0] b);
        for (int i = 15; i >= 0; i--) begin
            @(posedge mac_side.tx_bit_clock);
            mac_tx <= {1'b1, b[i]};
        end
        @(posedge mac_side.tx_bit_clock);
        mac_tx <= 2'h0;
        repeat (80) @(posedge clk_sys);
    endtask : mac_send
    task automatic t_clk;
        @(posedge mac_side.tx_bit_clock);
        t0 = $time;
        repeat (4) @(posedge mac_side.tx_bit_clock);
        check(8'(($time - t0 + 8) / 16), 8'h19);
        $display("test clock done");
    endtask : t_clk
    task automatic t_tx;
        clr();
        mac_send({8'haa, 8'h3c});
        check(sh_q, 8'h3c);
        check({tx_q, own_q}, 8'h03);
        $display("test transmit done");
    endtask : t_tx
    task automatic t_rx;
        clr();
        u_xcvr.send_bits({8'haa, 8'hc6});
        check(sh_q, 8'hc6);
        check({car_q, mac_side.carrier_present, own_q}, 8'h04);
        $display("test receive done");
    endtask : t_rx
    task automatic t_col;
        col_req <= 1'b1;
        repeat (60) @(posedge clk_sys);
        check(8'(mac_side.collision), 8'h01);
        col_req <= 1'b0;
        repeat (60) @(posedge clk_sys);
        check(8'(mac_side.collision), 8'h00);
        $display("test collision done");
    endtask : t_col
    task automatic t_loop;
        foreach (modes[k]) begin
            loop_mode <= modes[k];
            repeat (30) @(posedge clk_sys);
            clr();
            mac_send({8'haa, 8'h5a});
            check({tx_q, car_q}, {6'h00, modes[k] == LOOP_XCVR, 1'b1});
            if (modes[k] != LOOP_MAC) check(sh_q, 8'h5a);
        end
        loop_mode <= LOOP_NONE;
        $display("test loopback done");
    endtask : t_loop
    task automatic t_ext;
        external_codec_select <= 1'b1;
        ext_in <= 5'h15;
        mac_tx <= 2'h3;
        repeat (4) @(posedge clk_sys);
        check({6'h00, ext_tx}, 8'h03);
        check({3'h0, pin_side}, 8'h15);
        check({tx_line_p, tx_line_n}, 8'h00);
        $display("test bypass done");
    endtask : t_ext
    task automatic end_of_test;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_clk();
        t_tx();
        t_rx();
        t_col();
        t_loop();
        t_ext();
        end_of_test();
    end
endmodule : manchester_codec_unit_tb
